// File: hdl/lcim_io_map.v
// compatibility io map between cyclic fieldbus words and slave data
//
// Summary of operation
// - first mode word0 low nibble: active-low status
// - slave n inputs at word n/4 nibble n%4
// - word 8 extended status bits 0..4
// - extended status bits 5..8; 9..15 reserved zero
// - word 9 reserved; words 10/11 detected list
// - words 12..15 activated and projected lists
// - second mode: two stations, no messages
// - second mode: io data only, no status
// - second mode: word area only, no bit points
// - second mode inputs same, word0 nibble reserved
// - first mode: four stations, no messages
// - first mode omits command buffer and extras
`timescale 1ns/1ps
`include "lcim_regs.vh"

module lcim_io_map (
  input wire i_clk_sys,
  input wire i_nrst,
  input wire i_mode,
  input wire [127:0] i_slave_in,
  input wire i_cfg_err,
  input wire i_pwr_fail,
  input wire i_normal_inactive,
  input wire i_protected,
  input wire i_zero_addr,
  input wire i_auto_assign,
  input wire i_auto_avail,
  input wire i_cfg_mode,
  input wire i_offline,
  input wire i_no_periph_fault,
  input wire [31:0] i_detected_list,
  input wire [31:0] i_activated_list,
  input wire [31:0] i_projected_list,
  input wire [3:0] i_rd_idx,
  input wire i_wr_en,
  input wire [3:0] i_wr_idx,
  input wire [15:0] i_wr_data,
  output reg [15:0] o_rd_data,
  output reg [127:0] o_slave_out,
  output reg [3:0] o_out_flags,
  output wire [2:0] o_stations,
  output wire o_msg_supported,
  output wire [15:0] o_remote_bits
);

  // ***********************************************
  // mode and fixed attributes
  // ***********************************************
  reg mode_reg;
  reg mode_chg_reg;

  assign o_stations = (mode_reg == `LCIM_MODE_SECOND) ?
    `LCIM_STATIONS_SECOND : `LCIM_STATIONS_FIRST;
  // neither mode supports messaging; the command buffer is absent
  assign o_msg_supported = 1'b0;
  // remote bit points are unused in both modes
  assign o_remote_bits = 16'h0000;

  // ***********************************************
  // input word assembly
  // ***********************************************
  wire [15:0] status_nib_word;
  wire [15:0] ext_word;
  wire [255:0] in_map;

  assign status_nib_word = {12'h000,
    i_protected ? 1'b0 : 1'b1,
    i_normal_inactive,
    i_pwr_fail,
    i_cfg_err};

  assign ext_word = {7'h00,
    i_no_periph_fault,
    i_offline,
    i_pwr_fail,
    i_normal_inactive,
    i_cfg_mode,
    i_auto_avail,
    i_auto_assign,
    i_zero_addr,
    i_cfg_err};

  genvar g;
  generate
    for (g = 0; g < `LCIM_IO_WORDS; g = g + 1) begin : g_in
      // slave bit k lands on nibble bit k, so a word is a straight slice
      if (g == 0) begin : g_w0
        assign in_map[15:0] = {i_slave_in[15:4], (mode_reg == `LCIM_MODE_FIRST) ?
          status_nib_word[3:0] : 4'h0};
      end else begin : g_wn
        assign in_map[g*16+15:g*16] = i_slave_in[g*16+15:g*16];
      end
    end
  endgenerate

  assign in_map[143:128] = ext_word;
  assign in_map[159:144] = 16'h0000;
  assign in_map[175:160] = i_detected_list[15:0];
  assign in_map[191:176] = i_detected_list[31:16];
  assign in_map[207:192] = i_activated_list[15:0];
  assign in_map[223:208] = i_activated_list[31:16];
  assign in_map[239:224] = i_projected_list[15:0];
  assign in_map[255:240] = i_projected_list[31:16];

  // second mode exposes io words only; the status area reads as zero
  function [15:0] lcim_pick;
    input [255:0] map;
    input [3:0] idx;
    input md;
    begin
      if (md == `LCIM_MODE_SECOND && idx >= `LCIM_IDX_EXT_STATUS) begin
        lcim_pick = `LCIM_RESET_WORD;
      end else begin
        lcim_pick = map[idx*16 +: 16];
      end
    end
  endfunction

  // ***********************************************
  // registered read path and output words
  // ***********************************************
  always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      mode_reg <= `LCIM_MODE_FIRST;
      mode_chg_reg <= 1'b0;
      o_rd_data <= `LCIM_RESET_WORD;
      o_slave_out <= 128'h0;
      o_out_flags <= 4'h0;
    end else begin
      mode_reg <= i_mode;
      mode_chg_reg <= (i_mode != mode_reg);
      o_rd_data <= lcim_pick(in_map, i_rd_idx, mode_reg);
      if (mode_chg_reg) begin
        // drop outputs one cycle after mode_reg switches, so the old layout lasts at most one cycle
        o_slave_out <= 128'h0;
        o_out_flags <= 4'h0;
      end else if (i_wr_en && i_wr_idx < `LCIM_IDX_EXT_STATUS) begin
        if (i_wr_idx == 4'h0) begin
          o_slave_out[15:4] <= i_wr_data[15:4];
          // flags only meaningful in first mode; reserved nibble dropped
          o_out_flags <= (mode_reg == `LCIM_MODE_FIRST) ?
            i_wr_data[3:0] : 4'h0;
        end else begin
          o_slave_out[i_wr_idx*16 +: 16] <= i_wr_data;
        end
      end
      // writes to words 8..15 are reserved and ignored
    end
  end

endmodule // lcim_io_map

// File: include/lcim_regs.vh
// register indices, field positions and mode codes of the compatibility io map
`ifndef LCIM_REGS_VH
`define LCIM_REGS_VH
// ***********************************************
// word indices of the cyclic areas
// ***********************************************
`define LCIM_IN_WORDS 16
`define LCIM_OUT_WORDS 16
`define LCIM_IO_WORDS 8
`define LCIM_IDX_EXT_STATUS 4'h8
`define LCIM_IDX_IN_SPARE 4'h9
`define LCIM_IDX_DET_LO 4'ha
`define LCIM_IDX_DET_HI 4'hb
`define LCIM_IDX_ACT_LO 4'hc
`define LCIM_IDX_ACT_HI 4'hd
`define LCIM_IDX_PROJ_LO 4'he
`define LCIM_IDX_PROJ_HI 4'hf
// ***********************************************
// modes
// ***********************************************
`define LCIM_MODE_FIRST 1'b0
`define LCIM_MODE_SECOND 1'b1
`define LCIM_STATIONS_FIRST 3'h4
`define LCIM_STATIONS_SECOND 3'h2
// ***********************************************
// status nibble bits (active low)
// ***********************************************
`define LCIM_NIB_CFG_ERR_N 0
`define LCIM_NIB_PWR_OK_N 1
`define LCIM_NIB_NORMAL_N 2
`define LCIM_NIB_PROT_N 3
// ***********************************************
// extended status bits
// ***********************************************
`define LCIM_EXT_CFG_ERR 0
`define LCIM_EXT_ZERO_ADDR 1
`define LCIM_EXT_AUTO_ASSIGN 2
`define LCIM_EXT_AUTO_AVAIL 3
`define LCIM_EXT_CFG_MODE 4
`define LCIM_EXT_NORMAL_INACT 5
`define LCIM_EXT_PWR_FAIL 6
`define LCIM_EXT_OFFLINE 7
`define LCIM_EXT_NO_PERIPH_FAULT 8
`define LCIM_RESET_WORD 16'h0000
`endif

// File: verif/lcim_chk_sva.sv
// port assertions for the compatibility io map
`timescale 1ns/1ps
module lcim_chk(input wire i_clk_sys,i_nrst,i_mode,i_wr_en,input wire [3:0] i_rd_idx,i_wr_idx,
 o_out_flags,input wire [127:0] i_slave_in,o_slave_out,input wire [15:0] i_wr_data,o_rd_data,
 input wire [2:0] o_stations);
 reg [2:0] st_q=3'h4;
 // a mode change blanks one cycle, so f1 and s2 judge only a steady mode
 always @(posedge i_clk_sys) st_q<=o_stations;
 wire f1=o_stations==3'h4&&st_q==3'h4&&!i_mode;
 wire s2=o_stations==3'h2&&st_q==3'h2&&i_mode;
 default clocking @(posedge i_clk_sys); endclocking
 default disable iff (!i_nrst);
 AST_SLAVE: assert property (f1&&i_rd_idx==1|=>
  o_rd_data==$past(i_slave_in[31:16])) else $error("slave in");
 AST_WRITE: assert property (f1&&i_wr_en&&i_wr_idx==1|=>
  o_slave_out[31:16]==$past(i_wr_data)) else $error("out word");
 AST_FLAGS: assert property (f1&&i_wr_en&&i_wr_idx==0|=>
  o_out_flags==$past(i_wr_data[3:0])&&o_slave_out[3:0]==0) else $error("flags");
 AST_REFUSE: assert property (f1&&i_wr_en&&i_wr_idx[3]|=>
  $stable(o_slave_out)) else $error("spare write");
 AST_SEC_RD: assert property (s2&&i_rd_idx==0|=>
  o_rd_data=={$past(i_slave_in[15:4]),4'h0}) else $error("word0");
 AST_SEC_HI: assert property (s2&&i_rd_idx[3]|=>
  o_rd_data==0) else $error("no status");
 AST_SEC_WR: assert property (s2&&i_wr_en&&i_wr_idx==0|=>
  o_slave_out[15:0]=={$past(i_wr_data[15:4]),4'h0}&&o_out_flags==0) else $error("out0");
 AST_STATIONS: assert property ($past(i_nrst)|->
  o_stations==($past(i_mode)?3'h2:3'h4)) else $error("stations");
 cover property (f1&&i_wr_en);
 cover property (s2&&i_rd_idx==0);
 cover property ($rose(o_stations==3'h2));
endmodule // lcim_chk
bind lcim_io_map lcim_chk chk_u(.*);

// File: verif/lcim_ctl_model.sv
// controller model driving the cyclic word requests
`timescale 1ns/1ps
module lcim_ctl_model(input wire i_clk_sys,output reg [3:0] o_rd_idx=0,o_wr_idx=0,
 output reg o_wr_en=0,output reg [15:0] o_wr_data=0);
 task rd(input [3:0] a);
  begin @(posedge i_clk_sys); o_rd_idx<=a; @(posedge i_clk_sys); #1; end
 endtask
 task wr(input [3:0] a,input [15:0] d);
  begin @(posedge i_clk_sys); {o_wr_en,o_wr_idx,o_wr_data}<={1'b1,a,d};
   @(posedge i_clk_sys); {o_wr_en,o_wr_data}<={1'b0,~d}; #1; end
 endtask
endmodule // lcim_ctl_model

// File: verif/tb.sv
// self-checking bench for the compatibility io map
`timescale 1ns/1ps
module tb;
 localparam [127:0] P=128'hfedcba98_76543210_0f1e2d3c_4b5a6978;
 localparam [95:0] L=96'hffff0001_04002000_80010002;
 reg i_clk_sys=0,i_nrst=0,i_mode=0,i_cfg_err=0,i_pwr_fail=0,i_normal_inactive=0,i_protected=0,
  i_zero_addr=0,i_auto_assign=0,i_auto_avail=0,i_cfg_mode=0,i_offline=0,i_no_periph_fault=0;
 reg [127:0] i_slave_in=0;
 reg [31:0] i_detected_list=0,i_activated_list=0,i_projected_list=0;
 wire [3:0] i_rd_idx,i_wr_idx,o_out_flags;
 wire i_wr_en,o_msg_supported;
 wire [15:0] i_wr_data,o_rd_data,o_remote_bits;
 wire [127:0] o_slave_out;
 wire [2:0] o_stations;
 integer error_cnt=0,check_count=0,w;
 reg [15:0] e;
 lcim_io_map dut_u(.*);
 lcim_ctl_model pm_u(.i_clk_sys(i_clk_sys),.o_rd_idx(i_rd_idx),.o_wr_idx(i_wr_idx),
  .o_wr_en(i_wr_en),.o_wr_data(i_wr_data));
 task chk(input [15:0] s,x);
  begin check_count++;
   if(s!==x) begin error_cnt++; $display("FAIL %0t got %h exp %h",$time,s,x); end end
 endtask
 task stop_test;
  begin $display("errors %0d checks %0d",error_cnt,check_count);
   if(error_cnt==0&&check_count>0) $display("NO MISMATCHES");
   else $display("MISMATCHES SEEN");
   $finish; end
 endtask
 task t_first;
  begin @(posedge i_clk_sys); i_slave_in<=P; {i_projected_list,i_activated_list,i_detected_list}<=L;
   {i_protected,i_normal_inactive,i_pwr_fail,i_cfg_err}<=4'h5;
   {i_no_periph_fault,i_offline,i_auto_avail,i_zero_addr}<=4'hf;
   for(w=0;w<16;w++) begin pm_u.rd(w[3:0]);
    e=w<8?P[w*16+:16]:w==8?16'h01ab:w==9?16'h0:L[(w-10)*16+:16];
    if(w==0) e[3:0]=4'hd;
    chk(o_rd_data,e);
   end
   chk(o_remote_bits|{o_stations,o_msg_supported,12'h0},16'h8000);
   // flip every flag so a swapped or stuck status bit shows up
   @(posedge i_clk_sys); {i_protected,i_normal_inactive,i_pwr_fail,i_cfg_err}<=4'ha;
   {i_no_periph_fault,i_offline,i_auto_avail,i_zero_addr}<=4'h0;
   {i_auto_assign,i_cfg_mode}<=2'h3;
   pm_u.rd(4'h0);
   chk(o_rd_data,{P[15:4],4'h2});
   pm_u.rd(4'h8);
   chk(o_rd_data,16'h0054);
  end
 endtask
 task t_write;
  begin for(w=0;w<16;w++) pm_u.wr(w[3:0],{4{w[3:0]}}^16'h3c5a);
   for(w=0;w<8;w++) chk(o_slave_out[w*16+:16],w?{4{w[3:0]}}^16'h3c5a:16'h3c50);
   chk({12'h0,o_out_flags},16'h000a);
  end
 endtask
 task t_second;
  begin @(posedge i_clk_sys); i_mode<=1; repeat(2) @(posedge i_clk_sys); #1;
   chk(o_slave_out[127:112],16'h0);
   chk(o_remote_bits|{o_stations,o_msg_supported,12'h0},16'h4000);
   pm_u.rd(0);
   chk(o_rd_data,{P[15:4],4'h0});
   pm_u.rd(4'hc);
   chk(o_rd_data,16'h0000);
   pm_u.wr(0,16'hffff);
   chk(o_slave_out[15:0]|{12'h0,o_out_flags},16'hfff0);
  end
 endtask
 initial forever #2 i_clk_sys=~i_clk_sys;
 initial begin #9000; error_cnt++; stop_test; end
 initial begin repeat(20) @(posedge i_clk_sys); i_nrst<=1;
  t_first; t_write; t_second; stop_test; end
endmodule // tb
